// >>> dadc_ctrl.sv
// Output control of a dual 12-bit converter with APB register access
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dadc_ctrl #(
	parameter int unsigned RECOVERY_CYC = dadc_pkg::PD_RECOVERY_CYC
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [11:0]              sample_a_raw,
	input  wire logic [11:0]              sample_b_raw,
	output logic      [11:0]              data_a_out,
	output logic      [11:0]              data_a_oe,
	output logic      [11:0]              data_b_out,
	output logic      [11:0]              data_b_oe,
	output logic                          converter_run,
	output logic                          reference_external,
	output logic                          result_valid_a,
	output logic                          result_valid_b
);
	// Control bits: 0 chan_a_output_enable_n, 1 chan_b, 2 sleep_request,
	// 3 format_select, 4 reference_source_select, 5 spare
	logic [5:0]  ctrl_ff, nxt_ctrl;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, nxt_pready;
	logic        pslverr_ff, nxt_pslverr;
	logic        setup;
	logic        wr_hit;
	dadc_pkg::dadc_pair_s pair_ff, nxt_pair;
	logic [2:0]  flush_ff, nxt_flush;
	logic        val_a_ff, nxt_val_a, val_b_ff, nxt_val_b;
	logic        rec_busy_ff, nxt_rec_busy;
	logic [31:0] rec_cnt_ff, nxt_rec_cnt;
	logic        sleep;

	// A write commits only at the access edge on which pready is seen high
	assign setup = psel && !penable;
	assign wr_hit = psel && penable && pready_ff && pwrite &&
		(paddr == dadc_pkg::APB_OFF_CTRL);

	// Format encoding shared by both channels
	function automatic logic [11:0] dadc_fmt(input logic [11:0] ob, input logic twos);
		dadc_fmt = twos ? {~ob[11], ob[10:0]} : ob;
	endfunction : dadc_fmt

	// APB slave: answer one cycle after setup, zero wait beyond that
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		if (wr_hit) begin
			nxt_ctrl = pwdata[5:0];
		end
		if (setup) begin
			nxt_pready = 1'b1;
			if (pwrite) begin
				// Only the control word is writable
				nxt_pslverr = (paddr != dadc_pkg::APB_OFF_CTRL);
			end else begin
				case (paddr)
					dadc_pkg::APB_OFF_CTRL: nxt_prdata = {26'h0000000, ctrl_ff};
					dadc_pkg::APB_OFF_STAT: nxt_prdata = {28'h0000000, rec_busy_ff,
						flush_ff != 3'h0, val_a_ff, val_b_ff};
					dadc_pkg::APB_OFF_RES: nxt_prdata = {4'h0, pair_ff.a, 4'h0, pair_ff.b};
					default: begin
						nxt_prdata = 32'h00000000;
						nxt_pslverr = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= dadc_pkg::CTRL_RST;
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// Raw samples arrive from the converter core domain: two-stage sync
	logic [23:0] raw_s1_ff, raw_s2_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_s1_ff <= 24'h000000;
			raw_s2_ff <= 24'h000000;
		end else begin
			raw_s1_ff <= {sample_a_raw, sample_b_raw};
			raw_s2_ff <= raw_s1_ff;
		end
	end

	// Conversion pipeline and validity tracking
	assign sleep = ctrl_ff[2];

	always_comb begin
		nxt_pair = pair_ff;
		nxt_flush = flush_ff;
		nxt_rec_cnt = rec_cnt_ff;
		nxt_rec_busy = rec_busy_ff;
		if (sleep) begin
			// Pipeline content is lost; park at midscale
			nxt_pair.a = dadc_pkg::MID_CODE;
			nxt_pair.b = dadc_pkg::MID_CODE;
			nxt_flush = 3'(dadc_pkg::FLUSH_CYC);
			nxt_rec_cnt = RECOVERY_CYC;
			nxt_rec_busy = 1'b1;
		end else begin
			// Converts regardless of output enables
			nxt_pair.a = dadc_fmt(raw_s2_ff[23:12], ctrl_ff[3]);
			nxt_pair.b = dadc_fmt(raw_s2_ff[11:0], ctrl_ff[3]);
			if (flush_ff != 3'h0) nxt_flush = flush_ff - 3'h1;
			if (rec_cnt_ff != 32'h0) nxt_rec_cnt = rec_cnt_ff - 32'h1;
			nxt_rec_busy = (rec_cnt_ff > 32'h1);
		end
		// Valid only with enable low, awake, and stale words flushed
		nxt_val_a = !ctrl_ff[0] && !sleep && (flush_ff == 3'h0);
		nxt_val_b = !ctrl_ff[1] && !sleep && (flush_ff == 3'h0);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_ff <= '0;
			flush_ff <= 3'(dadc_pkg::FLUSH_CYC);
			val_a_ff <= 1'b0;
			val_b_ff <= 1'b0;
			rec_busy_ff <= 1'b0;
			rec_cnt_ff <= 32'h0;
		end else begin
			pair_ff <= nxt_pair;
			flush_ff <= nxt_flush;
			val_a_ff <= nxt_val_a;
			val_b_ff <= nxt_val_b;
			rec_busy_ff <= nxt_rec_busy;
			rec_cnt_ff <= nxt_rec_cnt;
		end
	end

	// Pin drive registers: enables follow the active-low controls
	logic [11:0] oe_a_ff, oe_b_ff;
	logic        run_ff, ref_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_a_ff <= 12'h000;
			oe_b_ff <= 12'h000;
			run_ff <= ~dadc_pkg::CTRL_RST[2]; // Matches the control reset value
			ref_ff <= 1'b0;
		end else begin
			oe_a_ff <= {12{!nxt_ctrl[0]}};
			oe_b_ff <= {12{!nxt_ctrl[1]}};
			run_ff <= !nxt_ctrl[2];
			ref_ff <= nxt_ctrl[4];
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign data_a_out = pair_ff.a;
	assign data_b_out = pair_ff.b;
	assign data_a_oe = oe_a_ff;
	assign data_b_oe = oe_b_ff;
	assign converter_run = run_ff;
	assign reference_external = ref_ff;
	assign result_valid_a = val_a_ff;
	assign result_valid_b = val_b_ff;

	// Assertions
	sequence s_wake;
		$fell(ctrl_ff[2]);
	endsequence
	property p_oe_off;
		@(posedge pclk) disable iff (!presetn) ctrl_ff[0] |-> data_a_oe == 12'h000;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("A pins driven while disabled");
	property p_oe_on;
		@(posedge pclk) disable iff (!presetn) !ctrl_ff[1] |-> data_b_oe == 12'hFFF;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("B pins not driven");
	property p_conv;
		@(posedge pclk) disable iff (!presetn)
			(!ctrl_ff[2] && ctrl_ff[0]) |=> data_a_out == dadc_fmt($past(raw_s2_ff[23:12]),
			$past(ctrl_ff[3]));
	endproperty
	a_conv: assert property (p_conv) else $error("Conversion stalled by enable");
	property p_sleep;
		@(posedge pclk) disable iff (!presetn) ctrl_ff[2] |-> !converter_run;
	endproperty
	a_sleep: assert property (p_sleep) else $error("Running during sleep");
	property p_flush;
		@(posedge pclk) disable iff (!presetn) s_wake |-> !result_valid_a [*4];
	endproperty
	a_flush: assert property (p_flush) else $error("Stale word marked valid");
	property p_fmt;
		@(posedge pclk) disable iff (!presetn)
			(!ctrl_ff[2] && !ctrl_ff[3]) |=> data_b_out == $past(raw_s2_ff[11:0]);
	endproperty
	a_fmt: assert property (p_fmt) else $error("Offset binary wrong");
	property p_twos;
		@(posedge pclk) disable iff (!presetn)
			(!ctrl_ff[2] && ctrl_ff[3]) |=> data_b_out[11] != $past(raw_s2_ff[11]);
	endproperty
	a_twos: assert property (p_twos) else $error("Top bit not inverted");
	property p_ref;
		@(posedge pclk) disable iff (!presetn) 1'b1 |=> reference_external == $past(nxt_ctrl[4]);
	endproperty
	a_ref: assert property (p_ref) else $error("Reference select lost");
	property p_valid;
		@(posedge pclk) disable iff (!presetn) (ctrl_ff[1] || ctrl_ff[2]) |=> !result_valid_b;
	endproperty
	a_valid: assert property (p_valid) else $error("Valid while disabled");
endmodule : dadc_ctrl
`default_nettype wire

// >>> dadc_pkg.sv
// Package for the dual converter output control block
package dadc_pkg;
	localparam int unsigned DATA_W = 12;
	localparam int unsigned CLK_MHZ = 10;
	localparam int unsigned PD_RECOVERY_US = 500;
	localparam int unsigned PD_RECOVERY_CYC = PD_RECOVERY_US * CLK_MHZ;
	localparam int unsigned FLUSH_CYC = 4;
	localparam logic [7:0] APB_OFF_CTRL = 8'h00;
	localparam logic [7:0] APB_OFF_STAT = 8'h04;
	localparam logic [7:0] APB_OFF_RES = 8'h08;
	localparam logic [5:0] CTRL_RST = 6'h03;
	localparam logic [11:0] MID_CODE = 12'h800;

	typedef struct packed {
		logic [11:0] a;
		logic [11:0] b;
	} dadc_pair_s;
endpackage : dadc_pkg

// >>> dadc_capture.sv
// Capture logic model that latches both result buses
`timescale 1ns/1ps
`default_nettype none
module dadc_capture #(
	parameter int unsigned DISCARD_CYC = 2
) (
	input  wire logic            pclk,
	input  wire logic [11:0]     out_a,
	input  wire logic [11:0]     oe_a,
	input  wire logic [11:0]     out_b,
	input  wire logic [11:0]     oe_b,
	input  wire logic            ok_a,
	input  wire logic            ok_b,
	output var dadc_pkg::dadc_pair_s pair,
	output logic                 pair_ok
);
	// Undriven pins read as the inverse of the last capture, never a stale match
	wire logic [11:0] pin_a = (oe_a & out_a) | (~oe_a & ~pair.a);
	wire logic [11:0] pin_b = (oe_b & out_b) | (~oe_b & ~pair.b);
	logic [7:0] skip_ff;
	// Both words taken together on the falling edge, as one pair
	always_ff @(negedge pclk) begin
		pair    <= '{a: pin_a, b: pin_b};
		// Words just after an enable are dropped to flush the pipeline
		if (!(ok_a && ok_b)) begin
			skip_ff <= 8'(DISCARD_CYC);
		end else if (skip_ff != 8'h00) begin
			skip_ff <= skip_ff - 8'h01;
		end
		pair_ok <= ok_a && ok_b && (skip_ff == 8'h00);
	end
endmodule : dadc_capture
`default_nettype wire

// >>> dual_adc_output_control_tb_top.sv
// Self-checking testbench of the dual converter output control
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_control_tb_top;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, rd;
	logic [11:0]          sample_a_raw, sample_b_raw, data_a_out, data_a_oe, data_b_out, data_b_oe;
	logic                 converter_run, reference_external, result_valid_a, result_valid_b;
	logic                 pair_ok;
	dadc_pkg::dadc_pair_s pair;
	int                   bad_count, compares, cyc;
	logic [11:0]          fmt_tab [3] = '{12'h000, 12'h800, 12'hFFF};

	// Short recovery count keeps the run brief
	dadc_ctrl #(.RECOVERY_CYC(20)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sample_a_raw, .sample_b_raw, .data_a_out,
		.data_a_oe, .data_b_out, .data_b_oe, .converter_run, .reference_external,
		.result_valid_a, .result_valid_b);
	dadc_capture PEER (.pclk, .out_a(data_a_out), .oe_a(data_a_oe), .out_b(data_b_out),
		.oe_b(data_b_oe), .ok_a(result_valid_a), .ok_b(result_valid_b), .pair, .pair_ok);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Setup then access; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		// Let an edge pass after a transfer so psel is never driven twice at once
		if (psel === 1'h1) @(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 16) chk("pready", 32'h1, 32'h0);
	endtask : apb

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// Bounded wait for both valid flags to reach a level
	task automatic wait_val(input logic [1:0] exp);
		int n;
		n = 0;
		while ({result_valid_a, result_valid_b} !== exp && n < 12) begin
			@(posedge pclk);
			n++;
		end
		chk("valid", {30'h0, exp}, {30'h0, result_valid_a, result_valid_b});
	endtask : wait_val

	task automatic t_reset;
		apb(1'h0, dadc_pkg::APB_OFF_CTRL, 32'h0);
		chk("ctrl", {26'h0, dadc_pkg::CTRL_RST}, rd);
		chk("oe_a", 32'h0, {20'h0, data_a_oe});
		chk("val", 32'h0, {31'h0, result_valid_a | result_valid_b});
		chk("run", 32'h1, {31'h0, converter_run});
	endtask : t_reset

	task automatic t_data;
		sample_a_raw <= 12'h123;
		sample_b_raw <= 12'hABC;
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h0);
		tick(5);
		chk("out_a", 32'h123, {20'h0, data_a_out});
		chk("oe_b", 32'hFFF, {20'h0, data_b_oe});
		apb(1'h0, dadc_pkg::APB_OFF_RES, 32'h0);
		chk("res", 32'h0123_0ABC, rd);
		wait_val(2'h3);
		tick(1);
		chk("pair", 32'h123ABC, {8'h0, pair});
		chk("pair_ok", 32'h1, {31'h0, pair_ok});
	endtask : t_data

	task automatic t_format;
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h8);
		for (int i = 0; i < 3; i++) begin
			sample_a_raw <= fmt_tab[i];
			tick(5);
			chk("twos", {20'h0, fmt_tab[i] ^ 12'h800}, {20'h0, data_a_out});
		end
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h0);
	endtask : t_format

	task automatic t_enable;
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h1);
		sample_a_raw <= 12'h456;
		tick(5);
		chk("oe_a", 32'h0, {20'h0, data_a_oe});
		chk("oe_b", 32'hFFF, {20'h0, data_b_oe});
		chk("val_a", 32'h0, {31'h0, result_valid_a});
		chk("conv_a", 32'h456, {20'h0, data_a_out});
		chk("pair_ok", 32'h0, {31'h0, pair_ok});
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h0);
	endtask : t_enable

	task automatic t_sleep;
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h4);
		tick(3);
		chk("run", 32'h0, {31'h0, converter_run});
		chk("val", 32'h0, {30'h0, result_valid_a, result_valid_b});
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h0);
		tick(1);
		chk("flush", 32'h0, {30'h0, result_valid_a, result_valid_b});
		chk("run", 32'h1, {31'h0, converter_run});
		wait_val(2'h3);
		// Host treats words as rough until the 20-cycle recovery runs out
		apb(1'h0, dadc_pkg::APB_OFF_STAT, 32'h0);
		chk("rec_busy", 32'hB, rd);
		tick(20);
		apb(1'h0, dadc_pkg::APB_OFF_STAT, 32'h0);
		chk("rec_done", 32'h3, rd);
	endtask : t_sleep

	task automatic t_misc;
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h10);
		tick(1);
		chk("ref", 32'h1, {31'h0, reference_external});
		apb(1'h1, dadc_pkg::APB_OFF_CTRL, 32'h0);
		tick(1);
		chk("ref", 32'h0, {31'h0, reference_external});
		apb(1'h0, 8'hF0, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'h1, dadc_pkg::APB_OFF_RES, 32'h0);
		chk("ro_write", 32'h1, {31'h0, err});
		apb(1'h0, dadc_pkg::APB_OFF_CTRL, 32'h0);
		chk("ctrl_kept", 32'h0, rd);
	endtask : t_misc

	task automatic end_sim;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	// Free-running clock
	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end

	// Hang guard; the run needs a little over a hundred cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			end_sim;
		end
	end

	// Reset, then every scenario in turn
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		sample_a_raw = 12'h0;
		sample_b_raw = 12'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_data;
		t_format;
		t_enable;
		t_sleep;
		t_misc;
		end_sim;
	end
endmodule : dual_adc_output_control_tb_top
`default_nettype wire
